// ---- logic/sir_pkg.sv ----
// Package of codes, states and command encodings for the interrupt reporting block
package sir_pkg;

    // Connection state of the controller
    typedef enum logic [1:0] {
        ST_DISC,
        ST_INIT,
        ST_TARG
    } sir_state_e;

    // Width of the host command code
    localparam int CMD_W = 5;

    // Host command encodings
    localparam logic [CMD_W-1:0] CMD_CHIP_RESET  = 5'h00;
    localparam logic [CMD_W-1:0] CMD_DISCONNECT  = 5'h01;
    localparam logic [CMD_W-1:0] CMD_PAUSE       = 5'h02;
    localparam logic [CMD_W-1:0] CMD_SELECT_ATN  = 5'h08;
    localparam logic [CMD_W-1:0] CMD_SELECT_NATN = 5'h09;
    localparam logic [CMD_W-1:0] CMD_RESELECT    = 5'h0a;
    localparam logic [CMD_W-1:0] CMD_RX_COMMAND  = 5'h10;
    localparam logic [CMD_W-1:0] CMD_RX_DATA     = 5'h11;
    localparam logic [CMD_W-1:0] CMD_RX_MSG_OUT  = 5'h12;
    localparam logic [CMD_W-1:0] CMD_RX_UNSPEC   = 5'h13;
    localparam logic [CMD_W-1:0] CMD_TX_STATUS   = 5'h14;
    localparam logic [CMD_W-1:0] CMD_TX_DATA     = 5'h15;
    localparam logic [CMD_W-1:0] CMD_TX_MSG_IN   = 5'h16;
    localparam logic [CMD_W-1:0] CMD_TX_UNSPEC   = 5'h17;

    // Interrupt register codes
    localparam logic [7:0] INT_NONE        = 8'h00;
    localparam logic [7:0] INT_FUNC_DONE   = 8'h01;
    localparam logic [7:0] INT_BUS_SERVICE = 8'h02;
    localparam logic [7:0] INT_DONE_ATN    = 8'h03;
    localparam logic [7:0] INT_NO_RESPONSE = 8'h04;
    localparam logic [7:0] INT_SELECTED    = 8'h08;
    localparam logic [7:0] INT_SELECTED_AT = 8'h0a;
    localparam logic [7:0] INT_RESELECTED  = 8'h10;
    localparam logic [7:0] INT_INVALID_CMD = 8'h40;

    // Parity error flag position in the auxiliary status byte
    localparam int AUX_PARITY_BIT = 6;

endpackage

// ---- logic/sir_sync.sv ----
// Two-stage synchroniser with a rising edge pulse taken from the settled stage
module sir_sync (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    // First stage, read only by the second stage
    logic meta_ff;
    // Settled copy and its previous value
    logic sync_ff;
    logic prev_ff;

    // Two flops absorb metastability before anything looks at the pin
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Level and edge only ever derive from settled stages
    assign level_o = sync_ff;
    assign rise_o = sync_ff & ~prev_ff;
endmodule

// ---- logic/sir_top.sv ----
// Interrupt reporting and command acceptance of a SCSI protocol controller
// What this block does
// - Interrupt read drops line, clears register, busy
// - Bus event beats same-cycle interrupting command
// - Disconnected and target states gate accepted commands; initiator state accepts all
// - Disconnected: selects, reselect, pause, chip reset
// - Selected without attention reports 0000 1000
// - Selected with attention reports 0000 1010
// - Reselected as initiator reports 0001 0000
// - Select done to initiator, reselect to target
// - No busy answer reports 0000 0100
// - Invalid command reports 0100 0000
// - Target state accepts transfers, pause, disconnect, reset
// - Idle target attention reports 0000 0010; mid-transfer it is only remembered
// - Clean target transfer reports 0000 0001
// - Attention during transfer reports 0000 0011
// - Parity error without attention: 01, parity set
// - Parity error with attention: 03, parity set
// - Reselection follow-up interrupt is left to initiator phase logic
module sir_top
    import sir_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic cmd_load_i,
    input wire logic [CMD_W-1:0] cmd_code_i,
    input wire logic int_reg_rd_i,
    input wire logic atn_pin_i,
    input wire logic sel_target_i,
    input wire logic sel_atn_i,
    input wire logic reselected_i,
    input wire logic func_done_i,
    input wire logic parity_err_i,
    input wire logic sel_timeout_i,
    output logic int_o,
    output logic [7:0] int_reg_o,
    output logic [7:0] aux_status_o,
    output logic [1:0] state_o,
    output logic cmd_busy_o,
    output logic cmd_start_o,
    output logic [CMD_W-1:0] cmd_exec_o,
    output logic cmd_abort_o,
    output logic pause_o,
    output logic disconnect_o,
    output logic chip_reset_o
);
    // Synchronised attention level and its rising edge
    logic atn_lvl;
    logic atn_rise;

    // Registered state of the block
    sir_state_e state_ff;
    logic [7:0] int_reg_ff;
    logic int_ff;
    logic parity_ff;
    logic busy_ff;
    logic atn_seen_ff;
    logic [CMD_W-1:0] cur_cmd_ff;
    logic start_ff;
    logic abort_ff;
    logic pause_ff;
    logic disc_ff;
    logic creset_ff;

    // Combinational decode
    logic cmd_valid;
    logic cmd_intr;
    logic ev_sel;
    logic ev_resel;
    logic ev_atn;
    logic ev_bus;
    logic ev_done;
    logic ev_tmo;
    logic load_intr;
    logic load_imm;
    logic load_bad;
    logic int_load;
    logic [7:0] nxt_int_code;
    sir_state_e nxt_state;

    // Attention arrives straight from the bus, so it is synchronised first
    sir_sync u_atn_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .async_i(atn_pin_i),
        .level_o(atn_lvl),
        .rise_o(atn_rise)
    );

    // Command validity per connection state
    // state gates commands
    always_comb begin
        cmd_valid = 1'b0;
        cmd_intr = 1'b0;
        case (state_ff)
            ST_DISC: begin
                case (cmd_code_i)
                    CMD_SELECT_ATN, CMD_SELECT_NATN, CMD_RESELECT: begin
                        cmd_valid = 1'b1;
                        cmd_intr = 1'b1;
                    end
                    CMD_PAUSE, CMD_CHIP_RESET: begin
                        cmd_valid = 1'b1;
                    end
                    default: begin
                        cmd_valid = 1'b0;
                    end
                endcase
            end
            ST_TARG: begin
                case (cmd_code_i)
                    CMD_RX_COMMAND, CMD_RX_DATA, CMD_RX_MSG_OUT, CMD_RX_UNSPEC,
                    CMD_TX_STATUS, CMD_TX_DATA, CMD_TX_MSG_IN, CMD_TX_UNSPEC: begin
                        cmd_valid = 1'b1;
                        cmd_intr = 1'b1;
                    end
                    CMD_PAUSE, CMD_DISCONNECT, CMD_CHIP_RESET: begin
                        cmd_valid = 1'b1;
                    end
                    default: begin
                        cmd_valid = 1'b0;
                    end
                endcase
            end
            // Initiator commands are checked by the transfer engine, not here
            default: begin
                cmd_valid = 1'b1;
                cmd_intr = (cmd_code_i != CMD_PAUSE) && (cmd_code_i != CMD_DISCONNECT)
                    && (cmd_code_i != CMD_CHIP_RESET);
            end
        endcase
    end

    // Event qualification
    always_comb begin
        ev_sel = sel_target_i && (state_ff == ST_DISC);
        ev_resel = reselected_i && (state_ff == ST_DISC);
        // Attention mid-transfer is only remembered; an idle target interrupts
        ev_atn = atn_rise && (state_ff == ST_TARG) && !busy_ff;
        ev_bus = ev_sel || ev_resel || ev_atn;
        ev_done = func_done_i && busy_ff;
        ev_tmo = sel_timeout_i && busy_ff;
        load_intr = cmd_load_i && cmd_valid && cmd_intr && !ev_bus;
        load_imm = cmd_load_i && cmd_valid && !cmd_intr && !ev_bus;
        load_bad = cmd_load_i && !cmd_valid && !ev_bus;
    end

    // Interrupt code selection, bus events first
    always_comb begin
        int_load = 1'b1;
        nxt_int_code = INT_NONE;
        if (ev_sel) begin
            nxt_int_code = sel_atn_i ? INT_SELECTED_AT : INT_SELECTED;
        end else if (ev_resel) begin
            nxt_int_code = INT_RESELECTED;
        end else if (ev_atn) begin
            nxt_int_code = INT_BUS_SERVICE;
        end else if (ev_done) begin
            nxt_int_code = (atn_seen_ff || atn_lvl) && (state_ff == ST_TARG) ? INT_DONE_ATN : INT_FUNC_DONE;
        end else if (ev_tmo) begin
            nxt_int_code = INT_NO_RESPONSE;
        end else if (load_bad) begin
            nxt_int_code = INT_INVALID_CMD;
        end else begin
            int_load = 1'b0;
        end
    end

    // Next connection state
    always_comb begin
        nxt_state = state_ff;
        if (load_imm && (cmd_code_i == CMD_CHIP_RESET)) begin
            nxt_state = ST_DISC;
        end else if (load_imm && (cmd_code_i == CMD_DISCONNECT)) begin
            nxt_state = ST_DISC;
        end else if (ev_sel) begin
            nxt_state = ST_TARG;
        end else if (ev_resel) begin
            // reselection makes us initiator; its follow-up report is initiator phase logic
            nxt_state = ST_INIT;
        end else if (ev_done && (state_ff == ST_DISC)) begin
            nxt_state = (cur_cmd_ff == CMD_RESELECT) ? ST_TARG : ST_INIT;
        end
    end

    // Connection state register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_DISC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Interrupt register and line; a new event wins over a same-cycle read
    // read clears, else holds
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_reg_ff <= INT_NONE;
            int_ff <= 1'b0;
        end else if (int_load) begin
            int_reg_ff <= nxt_int_code;
            int_ff <= 1'b1;
        end else if (int_reg_rd_i) begin
            int_reg_ff <= INT_NONE;
            int_ff <= 1'b0;
        end
    end

    // Parity flag follows each new report, set only by a parity completion
    // parity qualifier
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            parity_ff <= 1'b0;
        end else if (int_load) begin
            parity_ff <= ev_done && !ev_bus && parity_err_i;
        end
    end

    // Interrupting command in progress flag
    // busy cleared by read, abandon
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
        end else if (load_intr) begin
            busy_ff <= 1'b1;
        end else if (int_reg_rd_i || ev_done || ev_tmo || ev_bus || load_imm) begin
            busy_ff <= 1'b0;
        end
    end

    // Attention seen while a transfer runs, folded into its completion code
    // remember attention
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            atn_seen_ff <= 1'b0;
        end else if (load_intr) begin
            atn_seen_ff <= 1'b0;
        end else if (busy_ff && atn_lvl) begin
            atn_seen_ff <= 1'b1;
        end
    end

    // Accepted command handed to the transfer engine
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_cmd_ff <= CMD_CHIP_RESET;
            start_ff <= 1'b0;
        end else begin
            start_ff <= load_intr;
            if (load_intr) begin
                cur_cmd_ff <= cmd_code_i;
            end
        end
    end

    // One-cycle strobes for immediate commands and abandonment
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            abort_ff <= 1'b0;
            pause_ff <= 1'b0;
            disc_ff <= 1'b0;
            creset_ff <= 1'b0;
        end else begin
            abort_ff <= ev_bus && busy_ff;
            pause_ff <= load_imm && (cmd_code_i == CMD_PAUSE);
            disc_ff <= load_imm && (cmd_code_i == CMD_DISCONNECT);
            creset_ff <= load_imm && (cmd_code_i == CMD_CHIP_RESET);
        end
    end

    // Outputs straight from flops
    assign int_o = int_ff;
    assign int_reg_o = int_reg_ff;
    assign aux_status_o = {1'b0, parity_ff, 6'h00};
    assign state_o = state_ff;
    assign cmd_busy_o = busy_ff;
    assign cmd_start_o = start_ff;
    assign cmd_exec_o = cur_cmd_ff;
    assign cmd_abort_o = abort_ff;
    assign pause_o = pause_ff;
    assign disconnect_o = disc_ff;
    assign chip_reset_o = creset_ff;

    // Checks on the reporting behaviour
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_quiet;
        !sel_target_i && !reselected_i && !func_done_i && !sel_timeout_i && !cmd_load_i && !atn_rise;
    endsequence

    sequence s_select_done;
        (state_ff == ST_DISC) && busy_ff && func_done_i && !sel_target_i && !reselected_i
            && (cur_cmd_ff != CMD_RESELECT);
    endsequence

    a_read_clears_int: assert property ((int_reg_rd_i and s_quiet) |=> !int_o && int_reg_o == 8'h00 && !cmd_busy_o)
        else $error("interrupt not cleared by read");
    a_coincide_drop: assert property (cmd_load_i && sel_target_i && state_ff == ST_DISC |=> !cmd_start_o)
        else $error("command ran despite bus event");
    a_sel_noatn_code: assert property (sel_target_i && !sel_atn_i && state_ff == ST_DISC
        |=> int_reg_o == 8'h08 && int_o && state_o == ST_TARG)
        else $error("wrong selected code");
    a_sel_atn_code: assert property (sel_target_i && sel_atn_i && state_ff == ST_DISC |=> int_reg_o == 8'h0a)
        else $error("wrong selected with attention code");
    a_resel_code: assert property (reselected_i && !sel_target_i && state_ff == ST_DISC
        |=> int_reg_o == 8'h10 && state_o == ST_INIT)
        else $error("wrong reselected code");
    a_select_done: assert property (s_select_done |=> int_reg_o == 8'h01 && state_o == ST_INIT)
        else $error("select completion wrong");
    a_timeout_code: assert property (sel_timeout_i && busy_ff && !func_done_i && !ev_bus
        |=> int_reg_o == 8'h04)
        else $error("timeout code wrong");
    a_invalid_code: assert property (cmd_load_i && !cmd_valid && !ev_bus && !func_done_i && !sel_timeout_i
        |=> int_reg_o == 8'h40 && !cmd_start_o)
        else $error("invalid command not reported");
    a_atn_target: assert property (ev_atn |=> int_reg_o == 8'h02 && !cmd_start_o)
        else $error("attention not reported");
    a_parity_flag: assert property (ev_done && !ev_bus && parity_err_i |=> aux_status_o[AUX_PARITY_BIT]
        && int_reg_o[0])
        else $error("parity completion wrong");
    a_int_holds: assert property (int_o && !int_reg_rd_i |=> int_o)
        else $error("interrupt dropped without read");
endmodule

// ---- testbench/sir_engine_model.sv ----
// Behavioural model of the transfer engine and bus event sources facing the block
module sir_engine_model (
    input wire logic clk_sys_i,
    output logic atn_pin_o,
    output logic sel_target_o,
    output logic sel_atn_o,
    output logic reselected_o,
    output logic func_done_o,
    output logic parity_err_o,
    output logic sel_timeout_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet bus at time zero
    initial begin
        atn_pin_o = 1'b0;
        sel_target_o = 1'b0;
        sel_atn_o = 1'b0;
        reselected_o = 1'b0;
        func_done_o = 1'b0;
        parity_err_o = 1'b0;
        sel_timeout_o = 1'b0;
    end

    // One event pulse: 0 selection, 1 reselection, 2 completion, 3 timeout
    task automatic fire(input logic [1:0] kind, input logic qual);
        @(posedge clk_sys_i);
        case (kind)
            2'd0: begin
                sel_target_o <= 1'b1;
                sel_atn_o <= qual;
            end
            2'd1: reselected_o <= 1'b1;
            2'd2: begin
                func_done_o <= 1'b1;
                parity_err_o <= qual;
            end
            // programmed selection timeout has run out
            default: sel_timeout_o <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        sel_target_o <= 1'b0;
        reselected_o <= 1'b0;
        func_done_o <= 1'b0;
        sel_timeout_o <= 1'b0;
        // Qualifiers flip once stale so a design that samples them late sees the wrong value
        sel_atn_o <= ~sel_atn_o;
        parity_err_o <= ~parity_err_o;
    endtask

    // Attention level, changed freely since the block synchronises it
    task automatic set_atn(input logic lvl);
        @(posedge clk_sys_i);
        atn_pin_o <= lvl;
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the interrupt reporting block
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR %0t: mismatch got %0h expected %0h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sir_pkg::*;

    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cmd_load_i = 1'b0;
    logic [CMD_W-1:0] cmd_code_i = '0;
    logic int_reg_rd_i = 1'b0;
    logic atn_pin_i, sel_target_i, sel_atn_i, reselected_i, func_done_i, parity_err_i, sel_timeout_i;
    logic int_o, cmd_busy_o, cmd_start_o, cmd_abort_o, pause_o, disconnect_o, chip_reset_o;
    logic [7:0] int_reg_o, aux_status_o;
    logic [1:0] state_o;
    logic [CMD_W-1:0] cmd_exec_o;
    int n_errors = 0;
    int n_compared = 0;
    // Target transfer commands, all of them interrupting
    logic [CMD_W-1:0] tcodes [8] = '{CMD_RX_COMMAND, CMD_RX_DATA, CMD_RX_MSG_OUT, CMD_RX_UNSPEC,
                                     CMD_TX_STATUS, CMD_TX_DATA, CMD_TX_MSG_IN, CMD_TX_UNSPEC};
    logic [CMD_W-1:0] scodes [3] = '{CMD_SELECT_ATN, CMD_SELECT_NATN, CMD_RESELECT};

    // 200 MHz system clock
    always #2.5 clk_sys_i = ~clk_sys_i;

    sir_top i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_load_i(cmd_load_i),
        .cmd_code_i(cmd_code_i), .int_reg_rd_i(int_reg_rd_i), .atn_pin_i(atn_pin_i),
        .sel_target_i(sel_target_i), .sel_atn_i(sel_atn_i), .reselected_i(reselected_i),
        .func_done_i(func_done_i), .parity_err_i(parity_err_i), .sel_timeout_i(sel_timeout_i),
        .int_o(int_o), .int_reg_o(int_reg_o), .aux_status_o(aux_status_o), .state_o(state_o),
        .cmd_busy_o(cmd_busy_o), .cmd_start_o(cmd_start_o), .cmd_exec_o(cmd_exec_o),
        .cmd_abort_o(cmd_abort_o), .pause_o(pause_o), .disconnect_o(disconnect_o),
        .chip_reset_o(chip_reset_o));

    sir_engine_model i_eng (.clk_sys_i(clk_sys_i), .atn_pin_o(atn_pin_i), .sel_target_o(sel_target_i),
        .sel_atn_o(sel_atn_i), .reselected_o(reselected_i), .func_done_o(func_done_i),
        .parity_err_o(parity_err_i), .sel_timeout_o(sel_timeout_i));

    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Host loads one command; outputs are settled when this returns
    task automatic host_cmd(input logic [CMD_W-1:0] code);
        @(posedge clk_sys_i);
        cmd_load_i <= 1'b1;
        cmd_code_i <= code;
        @(posedge clk_sys_i);
        cmd_load_i <= 1'b0;
        #1;
    endtask

    // Engine event, answer settled on return
    task automatic ev(input logic [1:0] kind, input logic qual);
        i_eng.fire(kind, qual);
        #1;
    endtask

    // Interrupt service: both status bytes checked, then the read clears line, register and busy
    task automatic host_read(input logic [7:0] exp_int, input logic [7:0] exp_aux);
        `CHK(int_o, 1'b1)
        `CHK(int_reg_o, exp_int)
        `CHK(aux_status_o, exp_aux)
        @(posedge clk_sys_i);
        int_reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        int_reg_rd_i <= 1'b0;
        #1;
        `CHK(int_o, 1'b0)
        `CHK(int_reg_o, 8'h00)
        `CHK(cmd_busy_o, 1'b0)
    endtask

    // Bounded wait for the interrupt line; the synchroniser adds a few cycles
    task automatic wait_int(input int lim);
        int k;
        for (k = 0; k < lim && int_o !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        #1;
        if (int_o !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t: interrupt wait ran out", $time);
            wrap_up();
        end
    endtask

    // Immediate command: its pulse, and no interrupt follows
    task automatic host_imm(input logic [CMD_W-1:0] code, input logic [1:0] exp_st);
        host_cmd(code);
        `CHK({pause_o, disconnect_o, chip_reset_o},
            {code == CMD_PAUSE, code == CMD_DISCONNECT, code == CMD_CHIP_RESET})
        `CHK(state_o, exp_st)
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK(int_o, 1'b0)
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        #1;
        `CHK(state_o, ST_DISC)
        `CHK(int_o, 1'b0)
        // Select completes into the initiator state
        host_cmd(CMD_SELECT_ATN);
        `CHK({cmd_start_o, cmd_busy_o, cmd_exec_o}, {2'b11, CMD_SELECT_ATN})
        ev(2'd2, 1'b0);
        host_read(INT_FUNC_DONE, 8'h00);
        `CHK(state_o, ST_INIT)
        host_imm(CMD_CHIP_RESET, ST_DISC);
        $display("test select done");
        // Every select and reselect times out without a busy answer
        foreach (scodes[i]) begin
            host_cmd(scodes[i]);
            `CHK({cmd_start_o, cmd_exec_o}, {1'b1, scodes[i]})
            ev(2'd3, 1'b0);
            host_read(INT_NO_RESPONSE, 8'h00);
            `CHK(state_o, ST_DISC)
        end
        host_imm(CMD_PAUSE, ST_DISC);
        host_cmd(CMD_RX_DATA);
        `CHK(cmd_start_o, 1'b0)
        host_read(INT_INVALID_CMD, 8'h00);
        $display("test disconnected commands done");
        // Reselect completes into the target state
        host_cmd(CMD_RESELECT);
        ev(2'd2, 1'b0);
        host_read(INT_FUNC_DONE, 8'h00);
        `CHK(state_o, ST_TARG)
        foreach (tcodes[i]) begin
            host_cmd(tcodes[i]);
            `CHK({cmd_start_o, cmd_exec_o}, {1'b1, tcodes[i]})
            ev(2'd2, 1'b0);
            host_read(INT_FUNC_DONE, 8'h00);
        end
        host_cmd(CMD_SELECT_ATN);
        `CHK(cmd_start_o, 1'b0)
        host_read(INT_INVALID_CMD, 8'h00);
        $display("test target commands done");
        // Parity and attention outcomes of target transfers
        host_cmd(CMD_RX_DATA);
        ev(2'd2, 1'b1);
        host_read(INT_FUNC_DONE, 8'h40);
        // Restore state is sent before a retry; parity flag must be gone
        host_cmd(CMD_TX_MSG_IN);
        ev(2'd2, 1'b0);
        host_read(INT_FUNC_DONE, 8'h00);
        host_cmd(CMD_RX_COMMAND);
        i_eng.set_atn(1'b1);
        repeat (6) @(posedge clk_sys_i);
        #1;
        `CHK(int_o, 1'b0)
        ev(2'd2, 1'b0);
        host_read(INT_DONE_ATN, 8'h00);
        host_cmd(CMD_RX_MSG_OUT);
        ev(2'd2, 1'b1);
        host_read(INT_DONE_ATN, 8'h40);
        i_eng.set_atn(1'b0);
        repeat (5) @(posedge clk_sys_i);
        // Attention while idle as target
        i_eng.set_atn(1'b1);
        wait_int(8);
        host_read(INT_BUS_SERVICE, 8'h00);
        i_eng.set_atn(1'b0);
        repeat (5) @(posedge clk_sys_i);
        // Host asks why attention was raised
        host_cmd(CMD_RX_MSG_OUT);
        ev(2'd2, 1'b0);
        host_read(INT_FUNC_DONE, 8'h00);
        host_imm(CMD_PAUSE, ST_TARG);
        host_imm(CMD_DISCONNECT, ST_DISC);
        $display("test target status done");
        // Selection events; the line must hold with no read
        ev(2'd0, 1'b0);
        repeat (10) @(posedge clk_sys_i);
        #1;
        host_read(INT_SELECTED, 8'h00);
        `CHK(state_o, ST_TARG)
        host_imm(CMD_DISCONNECT, ST_DISC);
        ev(2'd0, 1'b1);
        host_read(INT_SELECTED_AT, 8'h00);
        // Identifier not yet known, so finish a function before disconnecting
        host_cmd(CMD_RX_MSG_OUT);
        ev(2'd2, 1'b0);
        host_read(INT_FUNC_DONE, 8'h00);
        host_imm(CMD_DISCONNECT, ST_DISC);
        ev(2'd1, 1'b0);
        host_read(INT_RESELECTED, 8'h00);
        `CHK(state_o, ST_INIT)
        host_imm(CMD_CHIP_RESET, ST_DISC);
        // Command loaded in the same cycle as a selection is dropped
        fork
            ev(2'd0, 1'b0);
            host_cmd(CMD_SELECT_ATN);
        join
        `CHK({cmd_start_o, cmd_busy_o}, 2'b00)
        host_read(INT_SELECTED, 8'h00);
        // Selection while a select runs abandons it
        host_imm(CMD_DISCONNECT, ST_DISC);
        host_cmd(CMD_SELECT_NATN);
        ev(2'd0, 1'b0);
        `CHK({cmd_abort_o, cmd_busy_o}, 2'b10)
        host_read(INT_SELECTED, 8'h00);
        $display("test selection events done");
        wrap_up();
    end
endmodule
